/* hw/pcd_params.svh */
// constants of the pin change detect block
// Behaviour
// - every implemented port pin may flag changes, singly or in any combination.
// - changeIrq needs the module enable, irq does not; flags still set without it.
// - each pin has rising and falling detectors armed by its enable bits.
// - both enable bits set means both edge polarities are detected.
// - an enabled edge sets the pin's sticky flag and requests an interrupt.
// - summary flag is the OR of every pin flag, read only.
// - writing zero clears a flag; a coincident edge keeps it set.
// - in sleep an enabled change wakes the device when module enable set.
// - flags are updated before the wake request is raised.
// - port A rise enables are bits 5..0, reset zero, bits 7..6 read zero.
// - port A fall enables are bits 5..0, read write, reset zero.
// - port A flags are bits 5..0, hardware set, software written, reset zero.
// - port B rise enables are bits 7..4, reset zero, bits 3..0 read zero.
// - port B fall enables are bits 7..4, reset zero, bits 3..0 read zero.
// - port B flags are bits 7..4, set by armed edges, software clearable.
// - the unit disable bit holds the edge enables and pin flags in their reset state.
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH
`define PCD_OFS_A_RISE    8'h00
`define PCD_OFS_A_FALL    8'h04
`define PCD_OFS_A_FLAGS   8'h08
`define PCD_OFS_B_RISE    8'h0C
`define PCD_OFS_B_FALL    8'h10
`define PCD_OFS_B_FLAGS   8'h14
`define PCD_OFS_CTRL      8'h18
`define PCD_OFS_SUMMARY   8'h1C
`define PCD_OFS_INT_STAT  8'h20
`define PCD_OFS_INT_MASK  8'h24
`define PCD_MASK_A        8'h3F
`define PCD_MASK_B        8'hF0
`define PCD_RESET_BYTE    8'h00
`define PCD_CTRL_IRQ_EN   0
`define PCD_CTRL_DISABLE  1
`define PCD_INT_EDGE      0
`define PCD_INT_WAKE      1
`define PCD_INT_BITS      2
`endif

/* hw/pcd_pkg.sv */
// types shared by the pin change detect block
package pcd_pkg;
  typedef logic [7:0]  pcd_byte_t;
  typedef logic [15:0] pcd_pins_t;
endpackage

/* hw/pin_change_detect.sv */
// pin change detector with wishbone register slave
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pcd_params.svh"

module pcd_pin_change_detect #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // port pins
  input  wire logic [7:0]        portAPin,
  input  wire logic [7:0]        portBPin,
  // core side
  input  wire logic              sleepMode,
  output logic                   changeIrqSummary,
  output logic                   changeIrq,
  output logic                   wakeRequest,
  output logic                   irq
);

  pcd_pkg::pcd_byte_t portARiseEnable;
  pcd_pkg::pcd_byte_t portAFallEnable;
  pcd_pkg::pcd_byte_t portAChangeFlags;
  pcd_pkg::pcd_byte_t portBRiseEnable;
  pcd_pkg::pcd_byte_t portBFallEnable;
  pcd_pkg::pcd_byte_t portBChangeFlags;
  logic               changeIrqEnable;
  logic               changeUnitDisable;
  logic [`PCD_INT_BITS-1:0] intStatus;
  logic [`PCD_INT_BITS-1:0] intMask;

  pcd_pkg::pcd_pins_t pinSync1;
  pcd_pkg::pcd_pins_t pinSync2;
  pcd_pkg::pcd_pins_t pinLast;
  pcd_pkg::pcd_pins_t riseSeen;
  pcd_pkg::pcd_pins_t fallSeen;
  pcd_pkg::pcd_pins_t riseArmed;
  pcd_pkg::pcd_pins_t fallArmed;
  pcd_pkg::pcd_pins_t pinMask;
  pcd_pkg::pcd_pins_t edgeHit;
  pcd_pkg::pcd_byte_t hitA;
  pcd_pkg::pcd_byte_t hitB;

  logic               busReq;
  logic               wrStrobe;
  logic               wrLane0;
  pcd_pkg::pcd_byte_t wrByte;
  logic [31:0]        next_readData;

  // ---------------------------------------------------------------
  // pin synchronisers; the first stage feeds only the second
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      logic pinRaw;
      assign pinRaw = (gi < 8) ? portAPin[gi % 8] : portBPin[gi % 8];
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          pinSync1[gi] <= 1'b0;
          pinSync2[gi] <= 1'b0;
          pinLast[gi]  <= 1'b0;
        end else begin
          pinSync1[gi] <= pinRaw;
          pinSync2[gi] <= pinSync1[gi];
          pinLast[gi]  <= pinSync2[gi];
        end
      end
      // one cycle per change because pinLast catches up next edge
      assign riseSeen[gi] = pinSync2[gi] & ~pinLast[gi];
      assign fallSeen[gi] = ~pinSync2[gi] & pinLast[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // edge qualification
  // ---------------------------------------------------------------
  assign riseArmed = {portBRiseEnable, portARiseEnable};
  assign fallArmed = {portBFallEnable, portAFallEnable};
  assign pinMask   = {`PCD_MASK_B, `PCD_MASK_A};

  // each detector armed separately, both may be armed at once
  assign edgeHit = ((riseSeen & riseArmed) | (fallSeen & fallArmed))
                   & pinMask & {16{~changeUnitDisable}};
  assign hitA = edgeHit[7:0];
  assign hitB = edgeHit[15:8];

  // ---------------------------------------------------------------
  // wishbone decode: ack one cycle after the request, write at ack
  // ---------------------------------------------------------------
  assign busReq   = cyc_i & stb_i;
  assign wrStrobe = busReq & we_i & ack_o;
  assign wrLane0  = wrStrobe & sel_i[0];
  assign wrByte   = dat_i[7:0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= busReq & ~ack_o;
    end
  end

  // ---------------------------------------------------------------
  // control register, not affected by the unit disable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      changeIrqEnable   <= 1'b0;
      changeUnitDisable <= 1'b0;
    end else if (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_CTRL)) begin
      changeIrqEnable   <= wrByte[`PCD_CTRL_IRQ_EN];
      changeUnitDisable <= wrByte[`PCD_CTRL_DISABLE];
    end
  end

  // ---------------------------------------------------------------
  // edge enables; a disabled unit is held at reset and drops writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portARiseEnable <= `PCD_RESET_BYTE;
      portAFallEnable <= `PCD_RESET_BYTE;
    end else if (changeUnitDisable) begin
      portARiseEnable <= `PCD_RESET_BYTE;
      portAFallEnable <= `PCD_RESET_BYTE;
    end else if (wrLane0) begin
      if (adr_i == ADDR_W'(`PCD_OFS_A_RISE))
        portARiseEnable <= wrByte & `PCD_MASK_A;
      if (adr_i == ADDR_W'(`PCD_OFS_A_FALL))
        portAFallEnable <= wrByte & `PCD_MASK_A;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portBRiseEnable <= `PCD_RESET_BYTE;
      portBFallEnable <= `PCD_RESET_BYTE;
    end else if (changeUnitDisable) begin
      portBRiseEnable <= `PCD_RESET_BYTE;
      portBFallEnable <= `PCD_RESET_BYTE;
    end else if (wrLane0) begin
      if (adr_i == ADDR_W'(`PCD_OFS_B_RISE))
        portBRiseEnable <= wrByte & `PCD_MASK_B;
      if (adr_i == ADDR_W'(`PCD_OFS_B_FALL))
        portBFallEnable <= wrByte & `PCD_MASK_B;
    end
  end

  // ---------------------------------------------------------------
  // sticky flags: a hit in the cycle of a write survives the write,
  // so a read-modify-write clear keeps a fresh edge only if it lands in the write cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portAChangeFlags <= `PCD_RESET_BYTE;
    end else if (changeUnitDisable) begin
      portAChangeFlags <= `PCD_RESET_BYTE;
    end else if (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_A_FLAGS)) begin
      portAChangeFlags <= (wrByte | hitA) & `PCD_MASK_A;
    end else begin
      portAChangeFlags <= portAChangeFlags | hitA;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portBChangeFlags <= `PCD_RESET_BYTE;
    end else if (changeUnitDisable) begin
      portBChangeFlags <= `PCD_RESET_BYTE;
    end else if (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_B_FLAGS)) begin
      portBChangeFlags <= (wrByte | hitB) & `PCD_MASK_B;
    end else begin
      portBChangeFlags <= portBChangeFlags | hitB;
    end
  end

  // ---------------------------------------------------------------
  // request, summary and wake; wake is taken from the flags so the
  // flags are already written when the core resumes
  // ---------------------------------------------------------------
  assign changeIrqSummary = |{portBChangeFlags, portAChangeFlags};
  assign changeIrq        = changeIrqSummary & changeIrqEnable;
  assign wakeRequest      = sleepMode & changeIrq;

  // ---------------------------------------------------------------
  // event status, write one to clear, set beats clear
  // ---------------------------------------------------------------
  logic [`PCD_INT_BITS-1:0] intEvent;
  assign intEvent[`PCD_INT_EDGE] = |edgeHit;
  assign intEvent[`PCD_INT_WAKE] = wakeRequest;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStatus <= '0;
    end else if (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_INT_STAT)) begin
      intStatus <= (intStatus & ~wrByte[`PCD_INT_BITS-1:0]) | intEvent;
    end else begin
      intStatus <= intStatus | intEvent;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intMask <= '0;
    end else if (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_INT_MASK)) begin
      intMask <= wrByte[`PCD_INT_BITS-1:0];
    end
  end

  assign irq = |(intStatus & intMask);

  // ---------------------------------------------------------------
  // read data, latched in the request cycle and shown with ack;
  // unmapped addresses answer zero
  // ---------------------------------------------------------------
  always_comb begin
    next_readData = '0;
    if (adr_i == ADDR_W'(`PCD_OFS_A_RISE))
      next_readData[7:0] = portARiseEnable;
    else if (adr_i == ADDR_W'(`PCD_OFS_A_FALL))
      next_readData[7:0] = portAFallEnable;
    else if (adr_i == ADDR_W'(`PCD_OFS_A_FLAGS))
      next_readData[7:0] = portAChangeFlags;
    else if (adr_i == ADDR_W'(`PCD_OFS_B_RISE))
      next_readData[7:0] = portBRiseEnable;
    else if (adr_i == ADDR_W'(`PCD_OFS_B_FALL))
      next_readData[7:0] = portBFallEnable;
    else if (adr_i == ADDR_W'(`PCD_OFS_B_FLAGS))
      next_readData[7:0] = portBChangeFlags;
    else if (adr_i == ADDR_W'(`PCD_OFS_CTRL)) begin
      next_readData[`PCD_CTRL_IRQ_EN]  = changeIrqEnable;
      next_readData[`PCD_CTRL_DISABLE] = changeUnitDisable;
    end else if (adr_i == ADDR_W'(`PCD_OFS_SUMMARY))
      next_readData[0] = changeIrqSummary;
    else if (adr_i == ADDR_W'(`PCD_OFS_INT_STAT))
      next_readData[`PCD_INT_BITS-1:0] = intStatus;
    else if (adr_i == ADDR_W'(`PCD_OFS_INT_MASK))
      next_readData[`PCD_INT_BITS-1:0] = intMask;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dat_o <= '0;
    end else if (busReq && !ack_o) begin
      dat_o <= next_readData;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_rise_sets_flag: assert property (
    ($rose(pinSync2[0]) && portARiseEnable[0] && !changeUnitDisable)
      |=> portAChangeFlags[0]) else $error("armed rise did not set flag");

  a_fall_sets_flag: assert property (
    ($fell(pinSync2[14]) && portBFallEnable[6] && !changeUnitDisable)
      |=> portBChangeFlags[6]) else $error("armed fall did not set flag");

  a_flag_set_wins: assert property (
    (hitA != 8'h00) |=> ((portAChangeFlags & $past(hitA)) == $past(hitA)))
    else $error("edge lost during flag write");

  a_irq_gated: assert property (
    (hitA != 8'h00 && !changeIrqEnable)
      |=> (changeIrqSummary && changeIrq == changeIrqEnable))
    else $error("flag or request wrong without module enable");

  a_summary_or: assert property (
    changeIrqSummary == ((portAChangeFlags | portBChangeFlags) != 8'h00))
    else $error("summary differs from flags");

  a_reserved_zero: assert property (
    ((portARiseEnable & ~`PCD_MASK_A) == 8'h00)
      && ((portBRiseEnable & ~`PCD_MASK_B) == 8'h00))
    else $error("unimplemented enable bit set");

  a_disable_holds: assert property (
    changeUnitDisable |=> (portAChangeFlags == 8'h00 && portBChangeFlags == 8'h00
      && portAFallEnable == 8'h00 && portBFallEnable == 8'h00))
    else $error("disabled unit left reset state");

  a_edge_single: assert property (
    riseSeen[3] |=> !riseSeen[3]) else $error("edge longer than one cycle");

  a_wake_follows: assert property (
    (sleepMode && changeIrqEnable && edgeHit != 16'h0000)
      |=> (wakeRequest || !sleepMode))
    else $error("wake missing for change in sleep");

  a_ack_single: assert property (
    ack_o |=> !ack_o) else $error("ack held two cycles");

  a_ack_after_req: assert property (
    ack_o |-> $past(busReq)) else $error("ack without request");

  // per-pin bookkeeping; these hold whatever the bus does
  a_both_edges: assert property (
    ($changed(pinSync2[2]) && portARiseEnable[2] && portAFallEnable[2]
      && !changeUnitDisable)
      |=> portAChangeFlags[2]) else $error("dual armed pin missed an edge");

  a_fall_a_sets: assert property (
    ($fell(pinSync2[1]) && portAFallEnable[1] && !changeUnitDisable)
      |=> portAChangeFlags[1]) else $error("armed fall on port a missed");

  a_rise_b_sets: assert property (
    ($rose(pinSync2[13]) && portBRiseEnable[5] && !changeUnitDisable)
      |=> portBChangeFlags[5]) else $error("armed rise on port b missed");

  a_fall_reserved: assert property (
    ((portAFallEnable & ~`PCD_MASK_A) == 8'h00)
      && ((portBFallEnable & ~`PCD_MASK_B) == 8'h00))
    else $error("unimplemented fall enable bit set");

  a_flag_reserved: assert property (
    ((portAChangeFlags & ~`PCD_MASK_A) == 8'h00)
      && ((portBChangeFlags & ~`PCD_MASK_B) == 8'h00))
    else $error("unimplemented flag bit set");

  a_flag_a_sticky: assert property (
    (hitA == 8'h00 && !changeUnitDisable
      && !(wrLane0 && adr_i == ADDR_W'(`PCD_OFS_A_FLAGS)))
      |=> $stable(portAChangeFlags)) else $error("port a flag moved without cause");

  a_flag_b_sticky: assert property (
    (hitB == 8'h00 && !changeUnitDisable
      && !(wrLane0 && adr_i == ADDR_W'(`PCD_OFS_B_FLAGS)))
      |=> $stable(portBChangeFlags)) else $error("port b flag moved without cause");

  a_flag_b_set_wins: assert property (
    (hitB != 8'h00) |=> ((portBChangeFlags & $past(hitB)) == $past(hitB)))
    else $error("port b edge lost during flag write");

  a_flag_clears: assert property (
    (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_A_FLAGS) && wrByte == 8'h00
      && hitA == 8'h00 && !changeUnitDisable)
      |=> (portAChangeFlags == 8'h00)) else $error("zero write left a flag set");

  a_status_edge: assert property (
    (edgeHit != 16'h0000) |=> intStatus[`PCD_INT_EDGE])
    else $error("edge missing from event status");

  a_status_w1c: assert property (
    (wrLane0 && adr_i == ADDR_W'(`PCD_OFS_INT_STAT) && wrByte[`PCD_INT_EDGE]
      && !intEvent[`PCD_INT_EDGE])
      |=> !intStatus[`PCD_INT_EDGE]) else $error("write one did not clear status");

  a_fall_single: assert property (
    fallSeen[1] |=> !fallSeen[1]) else $error("fall edge longer than one cycle");

  c_clear_with_edge: cover property (
    wrLane0 && adr_i == ADDR_W'(`PCD_OFS_A_FLAGS) && hitA != 8'h00);
  c_wake: cover property (wakeRequest);
  c_irq: cover property (irq);
  c_both_edges: cover property (hitA[2] && portARiseEnable[2] && portAFallEnable[2]);
  c_disabled_write: cover property (changeUnitDisable && wrLane0);

endmodule
`default_nettype wire

/* sim/pcd_port_model.sv */
// port pins and sleeping core that face the pin change detector
`timescale 1ns/1ns
`default_nettype none
module pcd_port_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // bench commands
  input  wire logic [7:0] levelA,
  input  wire logic [7:0] levelB,
  input  wire logic [7:0] toggleA,
  input  wire logic       enterSleep,
  // device side
  input  wire logic       wakeRequest,
  output logic      [7:0] portAPin,
  output logic      [7:0] portBPin,
  output logic            sleepMode
);
  // toggled pins flip every cycle, so any bus write lands on a live edge
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      portAPin <= 8'h00;
      portBPin <= 8'h00;
    end else begin
      portAPin <= (levelA & ~toggleA) | ((portAPin ^ toggleA) & toggleA);
      portBPin <= levelB;
    end
  end

  // core stays asleep until the detector asks for a wake
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepMode <= 1'b0;
    end else if (enterSleep) begin
      sleepMode <= 1'b1;
    end else if (wakeRequest) begin
      sleepMode <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/pcd_pin_change_detect_test.sv */
// self-checking bench for the pin change detector
`timescale 1ns/1ns
`default_nettype none
`include "pcd_params.svh"
module pcd_pin_change_detect_test;
  logic        core_clk;
  logic        reset_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] datW;
  logic [3:0]  sel;
  logic [3:0]  lane;
  logic [31:0] datR;
  logic        ack;
  logic [7:0]  portAPin;
  logic [7:0]  portBPin;
  logic        sleepMode;
  logic        changeIrqSummary;
  logic        changeIrq;
  logic        wakeRequest;
  logic        irq;
  logic [7:0]  levelA;
  logic [7:0]  levelB;
  logic [7:0]  toggleA;
  logic        enterSleep;
  logic [31:0] rd;
  logic [31:0] seen;
  logic [7:0]  ofs [6];
  logic [7:0]  msk [6];
  int          n_fail;
  int          n_compared;
  int          i;

  pcd_pin_change_detect pcd_pin_change_detect_inst (
    .core_clk(core_clk), .reset_n(reset_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .portAPin(portAPin), .portBPin(portBPin), .sleepMode(sleepMode),
    .changeIrqSummary(changeIrqSummary), .changeIrq(changeIrq),
    .wakeRequest(wakeRequest), .irq(irq));

  pcd_port_model pcd_port_model_inst (
    .core_clk(core_clk), .reset_n(reset_n), .levelA(levelA), .levelB(levelB),
    .toggleA(toggleA), .enterSleep(enterSleep), .wakeRequest(wakeRequest),
    .portAPin(portAPin), .portBPin(portBPin), .sleepMode(sleepMode));

  always #50 core_clk = ~core_clk;

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until ack is sampled high, released at that same edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    sel <= lane;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    if (ack !== 1'b1) begin
      n_fail++;
      $display("BAD bus ack expected 1 seen %b", ack);
      conclude();
    end
  endtask

  // extra edge lets the write land before outputs are looked at
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, seen);
    @(posedge core_clk);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, rd);
    chk(what, exp, rd);
  endtask

  // a pin change shows in the flags three edges after the pin moves
  task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] t);
    @(posedge core_clk);
    levelA <= a;
    levelB <= b;
    toggleA <= t;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic doze();
    @(posedge core_clk);
    enterSleep <= 1'b1;
    @(posedge core_clk);
    enterSleep <= 1'b0;
  endtask

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {cyc, stb, we, adr, datW} = '0;
    sel = 4'h0;
    lane = 4'h1;
    {levelA, levelB, toggleA, enterSleep} = '0;
    n_fail = 0;
    n_compared = 0;
    ofs = '{`PCD_OFS_A_RISE, `PCD_OFS_A_FALL, `PCD_OFS_A_FLAGS,
            `PCD_OFS_B_RISE, `PCD_OFS_B_FALL, `PCD_OFS_B_FLAGS};
    msk = '{8'h3F, 8'h3F, 8'h3F, 8'hF0, 8'hF0, 8'hF0};
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 10; i++) begin
      rdChk(8'(i * 4), 32'h0, "reset value");
    end
    rdChk(8'h30, 32'h0, "unmapped");
    // a write without lane 0 selected is acked but must not land
    lane = 4'h0;
    wr(`PCD_OFS_A_RISE, 32'h3F);
    lane = 4'h1;
    rdChk(`PCD_OFS_A_RISE, 32'h00, "unselected lane");
    for (i = 0; i < 6; i++) begin
      wr(ofs[i], 32'hFF);
      rdChk(ofs[i], {24'h0, msk[i]}, "implemented bits");
      wr(ofs[i], 32'h00);
    end
    // bit0 rise only, bit1 fall only, bit2 both; upper pins unarmed
    wr(`PCD_OFS_A_RISE, 32'h05);
    wr(`PCD_OFS_A_FALL, 32'h06);
    pins(8'h3F, 8'h00, 8'h00);
    rdChk(`PCD_OFS_A_FLAGS, 32'h05, "rise flags");
    chk("summary", 32'h1, {31'h0, changeIrqSummary});
    chk("irq while disabled", 32'h0, {31'h0, changeIrq});
    // clear only what was seen, leaving fresh edges alone
    bus(1'b0, `PCD_OFS_A_FLAGS, 32'h0, seen);
    bus(1'b0, `PCD_OFS_A_FLAGS, 32'h0, rd);
    wr(`PCD_OFS_A_FLAGS, rd & (seen ^ 32'hFF));
    rdChk(`PCD_OFS_A_FLAGS, 32'h00, "masked clear");
    pins(8'h00, 8'h00, 8'h00);
    rdChk(`PCD_OFS_A_FLAGS, 32'h06, "fall flags");
    wr(`PCD_OFS_B_RISE, 32'h30);
    wr(`PCD_OFS_B_FALL, 32'hC0);
    pins(8'h00, 8'hFF, 8'h00);
    rdChk(`PCD_OFS_B_FLAGS, 32'h30, "port b rise");
    pins(8'h00, 8'h00, 8'h00);
    rdChk(`PCD_OFS_B_FLAGS, 32'hF0, "port b fall");
    rdChk(`PCD_OFS_INT_STAT, 32'h01, "edge status");
    wr(`PCD_OFS_INT_MASK, 32'h01);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`PCD_OFS_INT_MASK, 32'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`PCD_OFS_CTRL, 32'h01);
    chk("irq enabled", 32'h1, {31'h0, changeIrq});
    wr(`PCD_OFS_INT_STAT, 32'h01);
    rdChk(`PCD_OFS_INT_STAT, 32'h00, "status cleared");
    wr(`PCD_OFS_A_FLAGS, 32'h00);
    wr(`PCD_OFS_B_FLAGS, 32'h00);
    chk("summary clear", 32'h0, {31'h0, changeIrqSummary});
    // bit2 toggles every cycle, so the clearing write meets an edge
    pins(8'h00, 8'h00, 8'h04);
    // freeze bit2 after one more flip: its last edge lands on the write edge
    levelA <= portAPin ^ 8'h04;
    toggleA <= 8'h00;
    wr(`PCD_OFS_A_FLAGS, 32'h00);
    rdChk(`PCD_OFS_A_FLAGS, 32'h04, "edge beats clear");
    pins(8'h00, 8'h00, 8'h00);
    wr(`PCD_OFS_A_FLAGS, 32'h00);
    wr(`PCD_OFS_INT_STAT, 32'h03);
    doze();
    pins(8'h01, 8'h00, 8'h00);
    chk("woken", 32'h0, {31'h0, sleepMode});
    rdChk(`PCD_OFS_A_FLAGS, 32'h01, "flag after wake");
    rdChk(`PCD_OFS_INT_STAT, 32'h03, "wake status");
    wr(`PCD_OFS_CTRL, 32'h00);
    doze();
    pins(8'h05, 8'h00, 8'h00);
    chk("no wake without enable", 32'h1, {31'h0, sleepMode});
    chk("no wake request", 32'h0, {31'h0, wakeRequest});
    rdChk(`PCD_OFS_A_FLAGS, 32'h05, "flag in sleep");
    wr(`PCD_OFS_CTRL, 32'h01);
    // the model leaves sleep on the edge after the request rises
    @(posedge core_clk);
    chk("late wake", 32'h0, {31'h0, sleepMode});
    wr(`PCD_OFS_CTRL, 32'h03);
    rdChk(`PCD_OFS_A_RISE, 32'h00, "disabled enables");
    wr(`PCD_OFS_A_RISE, 32'h3F);
    pins(8'h00, 8'h00, 8'h3F);
    rdChk(`PCD_OFS_A_RISE, 32'h00, "write dropped");
    rdChk(`PCD_OFS_A_FLAGS, 32'h00, "disabled flags");
    chk("disabled summary", 32'h0, {31'h0, changeIrqSummary});
    conclude();
  end
endmodule
`default_nettype wire
